// ==== ectt_timer.sv ====
/*
  Eight-bit free-running timer with two input captures, two output
  compares, rollover flag, clear-by-read flag sequences and APB access.
  Assumes pclk is the processor clock, capture and oscillator inputs are
  asynchronous pins, and slow_mode comes from logic on pclk.
*/
// Functional notes
// - Tick select: cpu/4, /2, /8, osc/8000
// - Oscillator tick unavailable in slow mode
// - Second edge select: 0 falling, 1 rising
// - Status resets zero; only freeze writable
// - First capture flag, cleared status-then-capture access
// - First match flag, cleared status-then-compare access
// - Rollover flag on FF to 00
// - Alias counter access keeps rollover flag
// - Second capture flag, cleared likewise
// - Second match flag, cleared likewise
// - Freeze stops prescaler, counter, compare pins
// - First capture holds counter at event
// - Second capture holds counter at event
// - Counter reads value, resets FC, write resets
// - Compare registers read/write, reset zero
// - Eleven registers at indices 3C to 46
// - Interrupt on enabled capture, match, rollover
`timescale 1ns/10ps
`default_nettype none

module ectt_timer
  import ectt_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH  = 12,
  parameter int unsigned OSC_DIV_CNT = OSC_DIVIDE
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  // Clock sources and power mode
  input  wire logic                  oscillator_derived_clock,
  input  wire logic                  slow_mode,
  // Capture pins
  input  wire logic                  first_capture_input,
  input  wire logic                  second_capture_input,
  // Compare pins
  output var  logic                  first_compare_output,
  output var  logic                  first_compare_output_oe,
  output var  logic                  second_compare_output,
  output var  logic                  second_compare_output_oe,
  // Interrupt
  output var  logic                  timer_irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (ADDR_WIDTH < 9 || ADDR_WIDTH > 32) begin
      $error("ADDR_WIDTH must lie between 9 and 32");
    end
    if (OSC_DIV_CNT < 2 || OSC_DIV_CNT > 65536) begin
      $error("OSC_DIV_CNT must lie between 2 and 65536");
    end
  end

  localparam logic [15:0] OSC_LAST = 16'(OSC_DIV_CNT - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [ADDR_WIDTH-1:0] addr,
                                   input logic [7:0]            idx);
    addr_is = (addr == ADDR_WIDTH'({idx, 2'h0}));
  endfunction

  function automatic logic [2:0] cpu_last(input logic [1:0] sel);
    if (sel == SRC_CPU_DIV2) begin
      cpu_last = CPU_DIV2_LAST;
    end else if (sel == SRC_CPU_DIV8) begin
      cpu_last = CPU_DIV8_LAST;
    end else begin
      cpu_last = CPU_DIV4_LAST;
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  ectt_ctl2_t  ctl2_r;
  ectt_ctl1_t  ctl1_r;
  ectt_flags_t flags_r;
  logic [4:0]  armed_r;
  logic        freeze_r;
  logic [7:0]  cnt_r;
  logic [7:0]  cmp1_r;
  logic [7:0]  cmp2_r;
  logic [7:0]  cap1_r;
  logic [7:0]  cap2_r;
  logic [4:0]  evt_st_r;
  logic [4:0]  evt_mask_r;
  logic [2:0]  presc_r;
  logic [15:0] osc_cnt_r;
  logic [2:0]  sync1_r;
  logic [2:0]  sync2_r;
  logic [2:0]  prev_r;
  logic [1:0]  cmp_lvl_r;
  logic [2:0]  fill_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        setup_ok;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [7:0]  wbyte;
  logic [31:0] rd_val;

  assign setup_ok = psel & penable & ~pready;
  assign acc      = psel & penable & pready & ~pslverr;
  assign wr       = acc & pwrite & pstrb[0];
  assign rd       = acc & ~pwrite;
  assign wbyte    = pwdata[7:0];

  logic hit_ctl2;
  logic hit_ctl1;
  logic hit_stat;
  logic hit_cap1;
  logic hit_cmp1;
  logic hit_cnt;
  logic hit_alias;
  logic hit_cap2;
  logic hit_cmp2;
  logic hit_est;
  logic hit_emask;

  assign hit_ctl2  = addr_is(paddr, IDX_CONTROL_TWO);
  assign hit_ctl1  = addr_is(paddr, IDX_CONTROL_ONE);
  assign hit_stat  = addr_is(paddr, IDX_STATUS);
  assign hit_cap1  = addr_is(paddr, IDX_CAPTURE_ONE);
  assign hit_cmp1  = addr_is(paddr, IDX_COMPARE_ONE);
  assign hit_cnt   = addr_is(paddr, IDX_COUNT);
  assign hit_alias = addr_is(paddr, IDX_COUNT_ALIAS);
  assign hit_cap2  = addr_is(paddr, IDX_CAPTURE_TWO);
  assign hit_cmp2  = addr_is(paddr, IDX_COMPARE_TWO);
  assign hit_est   = addr_is(paddr, IDX_EVENT_STATUS);
  assign hit_emask = addr_is(paddr, IDX_EVENT_MASK);

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    if (hit_ctl2) begin
      rd_val[7:0] = {ctl2_r[7:1], 1'b0};
    end else if (hit_ctl1) begin
      rd_val[7:0] = ctl1_r;
    end else if (hit_stat) begin
      rd_val[7:0] = {flags_r, freeze_r, 2'h0};
    end else if (hit_cap1) begin
      rd_val[7:0] = cap1_r;
    end else if (hit_cmp1) begin
      rd_val[7:0] = cmp1_r;
    end else if (hit_cnt || hit_alias) begin
      rd_val[7:0] = cnt_r;
    end else if (hit_cap2) begin
      rd_val[7:0] = cap2_r;
    end else if (hit_cmp2) begin
      rd_val[7:0] = cmp2_r;
    end else if (hit_est) begin
      rd_val[4:0] = evt_st_r;
    end else if (hit_emask) begin
      rd_val[4:0] = evt_mask_r;
    end else begin
      mapped = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB answer: one wait state, data and error from flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ok;
      pslverr <= setup_ok & ~mapped;
      if (setup_ok && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl2_r     <= CONTROL_RESET;
      ctl1_r     <= CONTROL_RESET;
      cmp1_r     <= COMPARE_RESET;
      cmp2_r     <= COMPARE_RESET;
      freeze_r   <= FREEZE_RESET;
      evt_mask_r <= FLAGS_RESET;
    end else if (wr) begin
      if (hit_ctl2) begin
        ctl2_r <= {wbyte[7:1], 1'b0};
      end
      if (hit_ctl1) begin
        ctl1_r <= wbyte;
      end
      if (hit_cmp1) begin
        cmp1_r <= wbyte;
      end
      if (hit_cmp2) begin
        cmp2_r <= wbyte;
      end
      if (hit_stat) begin
        freeze_r <= wbyte[STATUS_FREEZE_BIT];
      end
      if (hit_emask) begin
        evt_mask_r <= wbyte[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] pins_in;
  logic [2:0] rise;
  logic [2:0] fall;

  assign pins_in = {oscillator_derived_clock, second_capture_input, first_capture_input};
  assign rise    = sync2_r & ~prev_r & {3{fill_r[2]}};
  assign fall    = ~sync2_r & prev_r & {3{fill_r[2]}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      prev_r  <= 3'h0;
      fill_r  <= 3'h0;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      fill_r  <= {fill_r[1:0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and tick selection
  // ----------------------------------------------------------------
  logic cpu_tick;
  logic osc_tick;
  logic tick;
  logic osc_sel;

  assign osc_sel  = (ctl2_r.tick_source_select == SRC_OSC_DIV);
  assign cpu_tick = (presc_r == cpu_last(ctl2_r.tick_source_select));
  assign osc_tick = rise[2] & (osc_cnt_r == OSC_LAST);
  assign tick     = ~freeze_r & (osc_sel ? (osc_tick & ~slow_mode) : cpu_tick);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= 3'h0;
    end else if (!freeze_r || (wr && (hit_cnt || hit_alias))) begin
      if (cpu_tick || osc_sel || (wr && (hit_cnt || hit_alias))) begin
        presc_r <= 3'h0;
      end else begin
        presc_r <= presc_r + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_r <= 16'h0000;
    end else if (!freeze_r && rise[2]) begin
      if (osc_cnt_r == OSC_LAST) begin
        osc_cnt_r <= 16'h0000;
      end else begin
        osc_cnt_r <= osc_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter and events
  // ----------------------------------------------------------------
  logic       cnt_write;
  logic       cnt_run;
  logic [7:0] cnt_inc;
  logic       cap1_evt;
  logic       cap2_evt;
  logic       match1_evt;
  logic       match2_evt;
  logic       roll_evt;
  logic [4:0] evt;

  assign cnt_write  = wr & (hit_cnt | hit_alias);
  assign cnt_run    = tick & ~cnt_write;
  assign cnt_inc    = cnt_r + 8'h01;
  assign roll_evt   = cnt_run & (cnt_r == 8'hFF);
  assign match1_evt = cnt_run & (cnt_inc == cmp1_r);
  assign match2_evt = cnt_run & (cnt_inc == cmp2_r);
  assign cap1_evt   = ctl1_r.first_capture_edge_select ? rise[0] : fall[0];
  assign cap2_evt   = ctl2_r.second_capture_edge_select ? rise[1] : fall[1];
  assign evt = {cap1_evt | (ctl2_r.pulse_width_mode & match2_evt),
                match1_evt, roll_evt, cap2_evt, match2_evt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= COUNT_RESET;
    end else if (cnt_write) begin
      cnt_r <= COUNT_RESET;
    end else if (tick) begin
      cnt_r <= cnt_inc;
    end
  end

  // Capture values carry no reset; they are undefined until the first event.
  always_ff @(posedge pclk) begin
    if (cap1_evt) begin
      cap1_r <= cnt_r;
    end
    if (cap2_evt) begin
      cap2_r <= cnt_r;
    end
  end

  // ----------------------------------------------------------------
  // Status flags and clear-by-read sequence
  // ----------------------------------------------------------------
  logic [4:0] clr_hit;
  logic [4:0] clr;

  // The alias counter address is deliberately absent here.
  assign clr_hit = {hit_cap1, hit_cmp1, hit_cnt, hit_cap2, hit_cmp2};
  assign clr     = armed_r & clr_hit & {5{acc}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= FLAGS_RESET;
      armed_r <= FLAGS_RESET;
    end else begin
      // An event in the clearing cycle wins.
      flags_r <= evt | (flags_r & ~clr);
      if (rd && hit_stat) begin
        armed_r <= prdata[7:STATUS_FLAGS_LSB];
      end else begin
        armed_r <= armed_r & ~clr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sticky event status and interrupt
  // ----------------------------------------------------------------
  logic [4:0] w1c;
  logic       flag_req;

  assign w1c = (wr && hit_est) ? wbyte[4:0] : 5'h00;
  assign flag_req = (ctl1_r.capture_irq_enable & (flags_r.first_capture_flag | flags_r.second_capture_flag))
                  | (ctl1_r.match_irq_enable & (flags_r.first_match_flag | flags_r.second_match_flag))
                  | (ctl1_r.rollover_irq_enable & flags_r.rollover_flag);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_st_r  <= FLAGS_RESET;
      timer_irq <= 1'b0;
    end else begin
      evt_st_r  <= evt | (evt_st_r & ~w1c);
      timer_irq <= flag_req | (|(evt_st_r & evt_mask_r));
    end
  end

  // ----------------------------------------------------------------
  // Compare outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_lvl_r <= 2'h0;
    end else begin
      if (match1_evt || ctl1_r.force_one) begin
        cmp_lvl_r[0] <= ctl1_r.level_one;
      end
      if (match2_evt || ctl1_r.force_two) begin
        cmp_lvl_r[1] <= ctl1_r.level_two;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_compare_output     <= 1'b0;
      second_compare_output    <= 1'b0;
      first_compare_output_oe  <= 1'b0;
      second_compare_output_oe <= 1'b0;
    end else begin
      first_compare_output     <= cmp_lvl_r[0] & ~freeze_r;
      second_compare_output    <= cmp_lvl_r[1] & ~freeze_r;
      first_compare_output_oe  <= ctl2_r.first_output_enable & ~freeze_r;
      second_compare_output_oe <= ctl2_r.second_output_enable & ~freeze_r;
    end
  end

endmodule

`default_nettype wire

// ==== ectt_pkg.sv ====
/*
  Shared constants and types of the eight-bit capture/compare timer.
  Assumes a design that imports the whole package and an APB bus with
  32-bit data, where each register takes one aligned word.
*/
`default_nettype none

package ectt_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL_TWO     = 8'h3C;
  localparam logic [7:0] IDX_CONTROL_ONE     = 8'h3D;
  localparam logic [7:0] IDX_STATUS          = 8'h3E;
  localparam logic [7:0] IDX_CAPTURE_ONE     = 8'h3F;
  localparam logic [7:0] IDX_COMPARE_ONE     = 8'h40;
  localparam logic [7:0] IDX_COUNT           = 8'h41;
  localparam logic [7:0] IDX_COUNT_ALIAS     = 8'h42;
  localparam logic [7:0] IDX_CAPTURE_TWO     = 8'h43;
  localparam logic [7:0] IDX_COMPARE_TWO     = 8'h44;
  localparam logic [7:0] IDX_EVENT_STATUS    = 8'h45;
  localparam logic [7:0] IDX_EVENT_MASK      = 8'h46;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET       = 8'h00;
  localparam logic [7:0] COUNT_RESET         = 8'hFC;
  localparam logic [7:0] COMPARE_RESET       = 8'h00;
  localparam logic [4:0] FLAGS_RESET         = 5'h00;
  localparam logic       FREEZE_RESET        = 1'h0;

  // ----------------------------------------------------------------
  // Field positions and timing counts
  // ----------------------------------------------------------------
  localparam int unsigned STATUS_FLAGS_LSB   = 3;
  localparam int unsigned STATUS_FREEZE_BIT  = 2;
  localparam int unsigned OSC_DIVIDE         = 8000;
  localparam logic [2:0] CPU_DIV4_LAST       = 3'h3;
  localparam logic [2:0] CPU_DIV2_LAST       = 3'h1;
  localparam logic [2:0] CPU_DIV8_LAST       = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_CPU_DIV4 = 2'h0,
    SRC_CPU_DIV2 = 2'h1,
    SRC_CPU_DIV8 = 2'h2,
    SRC_OSC_DIV  = 2'h3
  } ectt_src_t;

  typedef struct packed {
    logic       first_output_enable;
    logic       second_output_enable;
    logic       one_pulse_mode;
    logic       pulse_width_mode;
    logic [1:0] tick_source_select;
    logic       second_capture_edge_select;
    logic       reserved;
  } ectt_ctl2_t;

  typedef struct packed {
    logic capture_irq_enable;
    logic match_irq_enable;
    logic rollover_irq_enable;
    logic force_two;
    logic force_one;
    logic level_two;
    logic first_capture_edge_select;
    logic level_one;
  } ectt_ctl1_t;

  // Same layout as status bits 7 down to 3.
  typedef struct packed {
    logic first_capture_flag;
    logic first_match_flag;
    logic rollover_flag;
    logic second_capture_flag;
    logic second_match_flag;
  } ectt_flags_t;

endpackage

`default_nettype wire

// ==== ectt_timer_assertions.sv ====
/*
  Port checker of the capture/compare timer: bus handshake, decode,
  freeze of the compare pins and interrupt gating.
  Assumes it is bound to ectt_timer and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none

module ectt_timer_checker
  import ectt_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = 12
) (
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Pins
  input wire logic                  oscillator_derived_clock,
  input wire logic                  slow_mode,
  input wire logic                  first_capture_input,
  input wire logic                  second_capture_input,
  input wire logic                  first_compare_output,
  input wire logic                  first_compare_output_oe,
  input wire logic                  second_compare_output,
  input wire logic                  second_compare_output_oe,
  input wire logic                  timer_irq
);
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  logic [ADDR_WIDTH-3:0] idx;
  logic                  bad, wr_done, rd_st, quiet, frz_r;
  logic [2:0]            en_r;
  logic [4:0]            mask_r;
  assign idx = paddr[ADDR_WIDTH-1:2];
  assign bad = (paddr[1:0] != 2'h0) || (idx < IDX_CONTROL_TWO) || (idx > IDX_EVENT_MASK);
  assign wr_done = psel && penable && pready && pwrite && !pslverr && pstrb[0];
  assign rd_st = psel && penable && pready && !pwrite && !pslverr && (idx == IDX_STATUS);
  assign quiet = (en_r == 3'h0) && (mask_r == 5'h00);

  // Shadows of the freeze bit, interrupt enables and event mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frz_r <= 1'b0;
      en_r <= 3'h0;
      mask_r <= 5'h00;
    end else if (wr_done) begin
      if (idx == IDX_STATUS) frz_r <= pwdata[2];
      if (idx == IDX_CONTROL_ONE) en_r <= pwdata[7:5];
      if (idx == IDX_EVENT_MASK) mask_r <= pwdata[4:0];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wait_then_ready: assert property (psel && $rose(penable) |=> pready)
    else $error("pready did not follow the access phase");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_bad_addr_err: assert property (psel && penable && pready |-> pslverr == bad)
    else $error("address decode error flag wrong");
  a_status_low_zero: assert property (rd_st |-> prdata[1:0] == 2'h0 && prdata[31:8] == 24'h0)
    else $error("status reserved bits not zero");
  a_freeze_oe_off: assert property (frz_r && $past(frz_r) |-> !first_compare_output_oe && !second_compare_output_oe)
    else $error("compare pin enable while frozen");
  a_freeze_pins_low: assert property (frz_r && $past(frz_r) |-> !first_compare_output && !second_compare_output)
    else $error("compare pin driven while frozen");
  a_irq_quiet_masked: assert property (quiet && $past(quiet) |-> !timer_irq)
    else $error("interrupt with all enables off");
  a_irq_on_flag: assert property (rd_st && ((en_r[2] && (prdata[7] || prdata[4])) || (en_r[1] && (prdata[6] || prdata[3]))
    || (en_r[0] && prdata[5])) |-> ##[0:1] timer_irq)
    else $error("enabled flag without interrupt");

  c_bus_error: cover property (pslverr);
  c_irq_rise: cover property ($rose(timer_irq));
  c_rollover_seen: cover property (rd_st && prdata[5]);
  c_frozen_pins: cover property (frz_r && $past(frz_r));
endmodule

bind ectt_timer ectt_timer_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .oscillator_derived_clock(oscillator_derived_clock), .slow_mode(slow_mode),
  .first_capture_input(first_capture_input), .second_capture_input(second_capture_input),
  .first_compare_output(first_compare_output), .first_compare_output_oe(first_compare_output_oe),
  .second_compare_output(second_compare_output), .second_compare_output_oe(second_compare_output_oe),
  .timer_irq(timer_irq));

`default_nettype wire

// ==== test_eight_bit_capture_compare_timer.sv ====
/*
  Self-checking bench of the capture/compare timer: map, tick sources,
  flag clear sequences, captures, freeze and interrupts.
  Assumes the package, the timer and its checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module test_eight_bit_capture_compare_timer;
  import ectt_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready, pslverr, er, irq, o1, o2, oe1, oe2;
  logic        osc = 1'b0, slow = 1'b0, cap1 = 1'b1, cap2 = 1'b1;
  logic [7:0]  rd, c, v;
  logic [7:0]  rst_idx[5] = '{IDX_STATUS, IDX_CONTROL_TWO, IDX_CONTROL_ONE, IDX_COMPARE_ONE, IDX_COMPARE_TWO};
  logic [7:0]  clr_idx[5] = '{IDX_CAPTURE_ONE, IDX_COMPARE_ONE, IDX_COUNT, IDX_CAPTURE_TWO, IDX_COMPARE_TWO};
  int          errors = 0, samples_checked = 0, cyc = 0, seed = 98, tend = 0;

  ectt_timer #(.ADDR_WIDTH(12), .OSC_DIV_CNT(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oscillator_derived_clock(osc), .slow_mode(slow),
    .first_capture_input(cap1), .second_capture_input(cap2), .first_compare_output(o1),
    .first_compare_output_oe(oe1), .second_compare_output(o2), .second_compare_output_oe(oe2),
    .timer_irq(irq));

  always #50 pclk = ~pclk;
  always #310 osc = ~osc;
  always @(posedge pclk) cyc <= cyc + 1;

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    tend = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask

  task automatic rdk(input logic [7:0] i);
    apb(1'b0, i, 8'h00);
  endtask

  // Accepts a seen value within tol of the expected one.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g, input int tol);
    logic [7:0] d;
    d = g - e + 8'(tol);
    samples_checked++;
    if ((d <= 8'(2 * tol)) !== 1'b1) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bit_is(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g}, 0);
  endtask

  task automatic clr_all;
    rdk(IDX_STATUS);
    foreach (clr_idx[j]) rdk(clr_idx[j]);
  endtask

  // Runs the counter from FC for a window; per is the tick period in ns.
  task automatic run(input logic [1:0] s, input int win, input int per, input int tol);
    int n;
    wr(IDX_STATUS, 8'h04);
    wr(s[0] ? IDX_COUNT_ALIAS : IDX_COUNT, 8'h00);
    wr(IDX_CONTROL_TWO, {4'h0, s, 2'h0});
    wr(IDX_STATUS, 8'h00);
    n = tend;
    repeat (win) @(posedge pclk);
    wr(IDX_STATUS, 8'h04);
    n = tend - n;
    rdk(IDX_COUNT);
    chk("count", 8'hFC + 8'(n * 100 / per), rd, tol);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    #1000000;
    errors++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdk(IDX_COUNT);
    chk("count reset", COUNT_RESET, rd, 0);
    foreach (rst_idx[j]) begin
      rdk(rst_idx[j]);
      chk("reset value", 8'h00, rd, 0);
    end
    wr(IDX_STATUS, 8'h04);
    clr_all();
    wr(IDX_STATUS, 8'hFC);
    rdk(IDX_STATUS);
    chk("status", 8'h04, rd, 0);
    rdk(8'h50);
    bit_is("bus error", 1'b1, er);
    v = 8'($random(seed));
    wr(IDX_CONTROL_ONE, v);
    rdk(IDX_CONTROL_ONE);
    chk("control one", v, rd, 0);
    wr(IDX_CONTROL_TWO, 8'hC0);
    repeat (2) @(posedge pclk);
    bit_is("pin enable frozen", 1'b0, oe1 | oe2);
    wr(IDX_STATUS, 8'h00);
    repeat (2) @(posedge pclk);
    bit_is("pin enable", 1'b1, oe1 & oe2);
    run(2'h0, 60, 400, 1);
    run(2'h1, 60, 200, 1);
    run(2'h2, 60, 800, 1);
    run(2'h3, 240, 2480, 2);
    slow <= 1'b1;
    run(2'h3, 240, 1000000, 0);
    slow <= 1'b0;
    wr(IDX_CONTROL_ONE, 8'h20);
    rdk(IDX_STATUS);
    bit_is("rollover", 1'b1, rd[5]);
    bit_is("irq", 1'b1, irq);
    rdk(IDX_COUNT_ALIAS);
    rdk(IDX_STATUS);
    bit_is("rollover kept", 1'b1, rd[5]);
    rdk(IDX_COUNT);
    rdk(IDX_STATUS);
    bit_is("rollover cleared", 1'b0, rd[5]);
    bit_is("irq off", 1'b0, irq);
    clr_all();
    v = 8'hFE + 8'($unsigned($random(seed)) % 8);
    wr(IDX_COMPARE_ONE, v);
    wr(IDX_COMPARE_TWO, v + 8'h03);
    wr(IDX_CONTROL_ONE, 8'h40);
    run(2'h0, 100, 400, 1);
    rdk(IDX_COMPARE_TWO);
    chk("compare two", v + 8'h03, rd, 0);
    rdk(IDX_STATUS);
    chk("match flags", 8'h48, rd & 8'h48, 0);
    bit_is("irq", 1'b1, irq);
    wr(IDX_COMPARE_ONE, v);
    rdk(IDX_COMPARE_TWO);
    rdk(IDX_STATUS);
    chk("match flags", 8'h00, rd & 8'h48, 0);
    rdk(IDX_COUNT);
    c = rd;
    wr(IDX_CONTROL_ONE, 8'h80);
    cap1 <= 1'b0;
    repeat (6) @(posedge pclk);
    rdk(IDX_STATUS);
    bit_is("capture one flag", 1'b1, rd[7]);
    bit_is("irq", 1'b1, irq);
    rdk(IDX_CAPTURE_ONE);
    chk("capture one", c, rd, 0);
    rdk(IDX_STATUS);
    bit_is("capture one flag", 1'b0, rd[7]);
    rdk(IDX_EVENT_STATUS);
    bit_is("event capture one", 1'b1, rd[4]);
    wr(IDX_EVENT_STATUS, 8'h1F);
    rdk(IDX_EVENT_STATUS);
    chk("event status", 8'h00, rd, 0);
    wr(IDX_CONTROL_ONE, 8'h1D);
    wr(IDX_EVENT_MASK, 8'h1F);
    cap1 <= 1'b1;
    repeat (6) @(posedge pclk);
    cap1 <= 1'b0;
    repeat (6) @(posedge pclk);
    bit_is("event irq", 1'b1, irq);
    wr(IDX_EVENT_MASK, 8'h00);
    repeat (2) @(posedge pclk);
    bit_is("masked irq", 1'b0, irq);
    wr(IDX_EVENT_MASK, 8'h1F);
    wr(IDX_EVENT_STATUS, 8'h1F);
    repeat (2) @(posedge pclk);
    bit_is("cleared irq", 1'b0, irq);
    for (int s = 0; s < 2; s++) begin
      wr(IDX_CONTROL_TWO, {6'h00, s[0], 1'b0});
      cap2 <= 1'b0;
      repeat (6) @(posedge pclk);
      rdk(IDX_STATUS);
      bit_is("capture two flag", !s[0], rd[4]);
      rdk(IDX_CAPTURE_TWO);
      cap2 <= 1'b1;
      repeat (6) @(posedge pclk);
      rdk(IDX_STATUS);
      bit_is("capture two flag", s[0], rd[4]);
      rdk(IDX_CAPTURE_TWO);
      chk("capture two", c, rd, 0);
    end
    wr(IDX_STATUS, 8'h00);
    repeat (2) @(posedge pclk);
    bit_is("compare pins", 1'b1, o1 & o2);
    final_report();
  end
endmodule

`default_nettype wire
